// *** logic/vfdcr_top.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - Annunciator byte holds four 2-bit segments
// - Annunciators exist only in single-row mode
// - Single-row: chars 0x20-0x4F, annunciators 0x50-0x7F
// - Dual-row: row one 0x20-0x4F, row two 0x50-0x7F
// - Character byte: top bit point, low seven glyph
// - Config bit zero: 0 shutdown, 1 run
// - Writes work in shutdown; display test overrides
// - Shutdown finishes period, halts oscillator, blanks tube
// - Pump square wave held low during shutdown
// - Filament waveforms held low during shutdown
// - First multiplex cycle after wake stays blanked
// - Lock blocks shift-limit, grids, map data writes
// - Map pointer stays writable while locked
// - Config bit two picks blink period
// - Blink-sync bit resets blink and multiplex timing
// - Global-clear bit wipes characters and annunciators
// - Config bit six selects 48 or 96 digits
// - Config read bit seven returns live blink phase
// - Data input sampled on rising serial clock
// - Serial out routed to chosen pin, always driven
// - Serial pins ignored while select is high
// - Sixteen-bit shifter latched on select rising
// - MSB first, bit fifteen clear means write
module vfdcr_top
  import vfdcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic multiplex_osc_i,
  output logic tube_blank_out_o,
  output logic pump_out_o,
  output logic filament_drive_a_o,
  output logic filament_drive_b_o,
  output logic aux_out_zero_o,
  output logic aux_out_one_o,
  output logic dual_row_o
);
  vfdcr_state_t st_q; // Registered state
  vfdcr_state_t st_d; // Next state
  logic [3:0] pin_s; // Synchronised pins
  logic sclk_s; // Serial clock, synced
  logic cs_s; // Chip select (low active), synced
  logic din_s; // Serial data, synced
  logic osc_s; // Multiplex oscillator, synced
  logic sclk_rise; // Rising serial edge under select
  logic sclk_fall; // Falling serial edge under select
  logic exec; // Frame latched this cycle
  logic is_rd; // Latched frame is a read
  logic [6:0] f_addr; // Latched address
  logic [7:0] f_data; // Latched data
  logic osc_rise; // Multiplex oscillator edge
  logic per_end; // Last oscillator edge of a period
  logic cyc_end; // Last period of a multiplex cycle
  logic sd_req; // Shutdown requested and not overridden
  logic wave_ok; // Waveform outputs may toggle
  logic [7:0] rd_val; // Read-back data
  logic [4:0] blink_lim; // Selected blink half period

  // Pins come from outside this clock, so they pass two flops
  vfdcr_sync u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .pins_i({multiplex_osc_i, din_i, cs_n_i, sclk_i}),
    .sync_o(pin_s)
  );

  assign sclk_s = pin_s[0];
  assign cs_s = pin_s[1];
  assign din_s = pin_s[2];
  assign osc_s = pin_s[3];

  // Cell index of a display address
  function automatic logic [6:0] cell_idx(input logic [6:0] a);
    cell_idx = a - `VFDCR_ADDR_CELL_LO;
  endfunction : cell_idx

  // True for an address inside the display data window
  function automatic logic in_cells(input logic [6:0] a);
    in_cells = (a >= `VFDCR_ADDR_CELL_LO) && (a <= `VFDCR_ADDR_CELL_HI);
  endfunction : in_cells

  // Pin function select: level, waveform or serial data out
  function automatic logic pin_drive(input logic [7:0] cfg,
                                     input logic wave,
                                     input logic sdo);
    case (cfg[7:6])
      `VFDCR_FN_LEVEL: pin_drive = cfg[0];
      `VFDCR_FN_WAVE: pin_drive = wave;
      `VFDCR_FN_DOUT: pin_drive = sdo;
      default: pin_drive = 1'b0;
    endcase
  endfunction : pin_drive

  // Edge finders read only the second synchroniser stage
  always_comb begin
    sclk_rise = !cs_s && sclk_s && !st_q.sclk_p;
    sclk_fall = !cs_s && !sclk_s && st_q.sclk_p;
    exec = cs_s && !st_q.cs_p;
    is_rd = st_q.sh[`VFDCR_FRAME_RD_BIT];
    f_addr = st_q.sh[14:8];
    f_data = st_q.sh[7:0];
    osc_rise = osc_s && !st_q.osc_p && (st_q.pw != VFDCR_PW_OFF);
    per_end = osc_rise &&
      (st_q.osc_cnt == 9'(`VFDCR_MUX_OSC_COUNT - 1));
    cyc_end = per_end && (st_q.grid_idx >= st_q.grids);
    sd_req = !st_q.cfg_s && !st_q.test;
    wave_ok = (st_q.pw == VFDCR_PW_RUN) || (st_q.pw == VFDCR_PW_WAKE);
    blink_lim = st_q.cfg_b ? `VFDCR_BLINK_FAST
                           : `VFDCR_BLINK_SLOW;
  end

  // Read-back multiplexer
  always_comb begin
    rd_val = 8'h00;
    case (f_addr)
      `VFDCR_ADDR_BLANK_POL: rd_val = {7'h00, st_q.blank_pol};
      `VFDCR_ADDR_GRIDS: rd_val = {2'h0, st_q.grids};
      `VFDCR_ADDR_CONFIG: begin
        // Clear and sync read back as zero, they are one-shot
        rd_val = {st_q.blink_ph, st_q.cfg_m, 3'h0, st_q.cfg_b,
                  st_q.cfg_l, st_q.cfg_s};
      end
      `VFDCR_ADDR_OUT_MAP: rd_val = st_q.omap[st_q.map_ptr];
      `VFDCR_ADDR_TEST: rd_val = {7'h00, st_q.test};
      `VFDCR_ADDR_PUMP: rd_val = st_q.pump_cfg;
      `VFDCR_ADDR_FIL_A: rd_val = st_q.fa_cfg;
      `VFDCR_ADDR_FIL_B: rd_val = st_q.fb_cfg;
      `VFDCR_ADDR_AUX0: rd_val = st_q.a0_cfg;
      `VFDCR_ADDR_AUX1: rd_val = st_q.a1_cfg;
      `VFDCR_ADDR_SHIFT_LIM: rd_val = {1'b0, st_q.shlim};
      default: begin
        if (in_cells(f_addr)) begin
          rd_val = st_q.cells[cell_idx(f_addr)];
        end
      end
    endcase
  end

  // Next-state logic of the whole block
  always_comb begin
    st_d = st_q;
    st_d.sclk_p = sclk_s;
    st_d.cs_p = cs_s;
    st_d.osc_p = osc_s;

    // Serial shifter: runs only under select, keeps last 16 bits
    if (sclk_rise) begin
      st_d.sh = {st_q.sh[14:0], din_s};
    end
    if (sclk_fall) begin
      st_d.dout = st_q.sh[15];
    end

    // Frame execution when select rises
    if (exec && is_rd) begin
      st_d.sh = {st_q.sh[15:8], rd_val};
      st_d.dout = st_q.sh[15];
    end else if (exec) begin
      case (f_addr)
        `VFDCR_ADDR_NOP: begin
          // No-op keeps daisy chains safe
        end
        `VFDCR_ADDR_BLANK_POL: st_d.blank_pol = f_data[0];
        `VFDCR_ADDR_GRIDS: begin
          if (!st_q.cfg_l) begin
            st_d.grids = f_data[5:0];
          end
        end
        `VFDCR_ADDR_SHIFT_LIM: begin
          if (!st_q.cfg_l) begin
            st_d.shlim = f_data[6:0];
          end
        end
        `VFDCR_ADDR_OUT_MAP: begin
          if (f_data[`VFDCR_MAP_PTR_SET]) begin
            st_d.map_ptr = f_data[6:0];
          end else if (!st_q.cfg_l) begin
            st_d.omap[st_q.map_ptr] = f_data;
            st_d.map_ptr = st_q.map_ptr + 7'h01;
          end
        end
        `VFDCR_ADDR_TEST: st_d.test = f_data[0];
        `VFDCR_ADDR_PUMP: st_d.pump_cfg = f_data;
        `VFDCR_ADDR_FIL_A: st_d.fa_cfg = f_data;
        `VFDCR_ADDR_FIL_B: st_d.fb_cfg = f_data;
        `VFDCR_ADDR_AUX0: st_d.a0_cfg = f_data;
        `VFDCR_ADDR_AUX1: st_d.a1_cfg = f_data;
        `VFDCR_ADDR_CONFIG: begin
          st_d.cfg_s = f_data[`VFDCR_CFG_S];
          st_d.cfg_l = f_data[`VFDCR_CFG_L];
          st_d.cfg_b = f_data[`VFDCR_CFG_B];
          st_d.cfg_m = f_data[`VFDCR_CFG_M];
          if (f_data[`VFDCR_CFG_R]) begin
            st_d.cells = '0;
          end
        end
        default: begin
          // Display cells: one byte each, written in any power state.
          // The byte means glyph plus point, or four 2-bit annunciator
          // fields, depending on address and active mode.
          if (in_cells(f_addr)) begin
            st_d.cells[cell_idx(f_addr)] = f_data;
          end
        end
      endcase
    end

    // Multiplex timing, frozen while the oscillator is halted
    if (osc_rise) begin
      st_d.osc_cnt = st_q.osc_cnt + 9'h001;
    end
    if (per_end) begin
      st_d.osc_cnt = 9'h000;
      st_d.sq = !st_q.sq;
      st_d.grid_idx = st_q.grid_idx + 6'h01;
      if (st_q.blink_cnt >= blink_lim) begin
        st_d.blink_cnt = 5'h00;
        st_d.blink_ph = !st_q.blink_ph;
      end else begin
        st_d.blink_cnt = st_q.blink_cnt + 5'h01;
      end
    end
    if (cyc_end) begin
      st_d.grid_idx = 6'h00;
      st_d.mode_act = st_q.cfg_m;
    end

    // Blink sync restarts blink and scan; may flicker once
    if (exec && !is_rd && (f_addr == `VFDCR_ADDR_CONFIG) &&
        f_data[`VFDCR_CFG_T]) begin
      st_d.osc_cnt = 9'h000;
      st_d.grid_idx = 6'h00;
      st_d.blink_cnt = 5'h00;
      st_d.blink_ph = 1'b1;
    end

    // Power sequencing
    case (st_q.pw)
      VFDCR_PW_RUN: begin
        if (sd_req) begin
          st_d.pw = VFDCR_PW_DRAIN;
        end
      end
      VFDCR_PW_DRAIN: begin
        // Current period completes before the oscillator stops
        if (!sd_req) begin
          st_d.pw = VFDCR_PW_WAKE;
        end else if (per_end) begin
          st_d.pw = VFDCR_PW_OFF;
        end
      end
      VFDCR_PW_OFF: begin
        if (!sd_req) begin
          st_d.pw = VFDCR_PW_WAKE;
          st_d.osc_cnt = 9'h000;
          st_d.grid_idx = 6'h00;
        end
      end
      VFDCR_PW_WAKE: begin
        // Tube still holds stale data: blank one whole cycle
        if (sd_req) begin
          st_d.pw = VFDCR_PW_DRAIN;
        end else if (cyc_end) begin
          st_d.pw = VFDCR_PW_RUN;
        end
      end
      default: st_d.pw = VFDCR_PW_OFF;
    endcase

    // Registered pin outputs; waveforms low unless running or waking
    st_d.blank_o = (st_q.pw != VFDCR_PW_RUN) ? !st_q.blank_pol
                                           : st_q.blank_pol;
    st_d.pump_o = pin_drive(st_q.pump_cfg, st_q.sq && wave_ok,
                            st_q.dout);
    st_d.fa_o = pin_drive(st_q.fa_cfg, st_q.sq && wave_ok,
                          st_q.dout);
    st_d.fb_o = pin_drive(st_q.fb_cfg, !st_q.sq && wave_ok,
                          st_q.dout);
    st_d.a0_o = pin_drive(st_q.a0_cfg, st_q.sq && wave_ok,
                          st_q.dout);
    st_d.a1_o = pin_drive(st_q.a1_cfg, st_q.sq && wave_ok, st_q.dout);
    st_d.dual_o = st_q.mode_act;
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= '0;
      st_q.sclk_p <= 1'b1;
      st_q.cs_p <= 1'b1;
      st_q.shlim <= `VFDCR_RST_SHIFT_LIM;
      st_q.a1_cfg <= `VFDCR_RST_AUX1;
      st_q.a1_o <= 1'b1;
      st_q.map_ptr <= `VFDCR_RST_MAP_PTR;
      st_q.blink_ph <= 1'b1;
      st_q.blank_o <= 1'b1;
      st_q.pw <= VFDCR_PW_OFF;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign tube_blank_out_o = st_q.blank_o;
  assign pump_out_o = st_q.pump_o;
  assign filament_drive_a_o = st_q.fa_o;
  assign filament_drive_b_o = st_q.fb_o;
  assign aux_out_zero_o = st_q.a0_o;
  assign aux_out_one_o = st_q.a1_o;
  assign dual_row_o = st_q.dual_o;

  // Checks
  property p_lock_grids;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && exec && !is_rd && st_q.cfg_l &&
       f_addr == `VFDCR_ADDR_GRIDS) |=> $stable(st_q.grids);
  endproperty
  a_lock_grids: assert property (p_lock_grids)
    else $error("grids changed while locked");

  property p_idle_shift;
    @(posedge clk_i) disable iff (!rstn_i)
      (cs_s && !exec) |=> $stable(st_q.sh);
  endproperty
  a_idle_shift: assert property (p_idle_shift)
    else $error("shifter moved while deselected");

  property p_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && exec && !is_rd && f_addr == `VFDCR_ADDR_CONFIG &&
       f_data[`VFDCR_CFG_R]) |=> (st_q.cells == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("global clear left data");

  property p_off_low;
    @(posedge clk_i) disable iff (!rstn_i)
      ($past(st_q.pw) == VFDCR_PW_OFF &&
       $past(st_q.pump_cfg[7:6]) == `VFDCR_FN_WAVE) |-> !st_q.pump_o;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("pump wave active in shutdown");

  property p_blank;
    @(posedge clk_i) disable iff (!rstn_i)
      ($past(st_q.pw) == VFDCR_PW_WAKE) |->
        (st_q.blank_o == !$past(st_q.blank_pol));
  endproperty
  a_blank: assert property (p_blank)
    else $error("tube not blanked after wake");

  property p_halt;
    @(posedge clk_i) disable iff (!rstn_i)
      (st_q.pw == VFDCR_PW_OFF && !exec) |=> $stable(st_q.blink_cnt);
  endproperty
  a_halt: assert property (p_halt)
    else $error("timing ran while halted");

  property p_phase_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && exec && is_rd && f_addr == `VFDCR_ADDR_CONFIG) |=>
        (st_q.sh[`VFDCR_CFG_P] == $past(st_q.blink_ph));
  endproperty
  a_phase_rd: assert property (p_phase_rd)
    else $error("blink phase read wrong");

  property p_sync;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && exec && !is_rd && f_addr == `VFDCR_ADDR_CONFIG &&
       f_data[`VFDCR_CFG_T]) |=>
        (st_q.osc_cnt == 9'h000 && st_q.blink_cnt == 5'h00);
  endproperty
  a_sync: assert property (p_sync)
    else $error("blink sync did not restart timing");

  property p_mode;
    @(posedge clk_i) disable iff (!rstn_i)
      $changed(st_q.mode_act) |-> $past(cyc_end);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed mid cycle");

  c_read: cover property (@(posedge clk_i) disable iff (!rstn_i)
    exec && is_rd);
  c_off: cover property (@(posedge clk_i) disable iff (!rstn_i)
    st_q.pw == VFDCR_PW_DRAIN ##1 st_q.pw == VFDCR_PW_OFF);
  c_wake: cover property (@(posedge clk_i) disable iff (!rstn_i)
    st_q.pw == VFDCR_PW_WAKE ##1 st_q.pw == VFDCR_PW_RUN);
endmodule : vfdcr_top

// *** logic/vfdcr_params.svh ***
`ifndef VFDCR_PARAMS_SVH
`define VFDCR_PARAMS_SVH

// Register addresses (7-bit command address, bits 14:8 of a frame)
`define VFDCR_ADDR_NOP 7'h00
`define VFDCR_ADDR_BLANK_POL 7'h01
`define VFDCR_ADDR_GRIDS 7'h03
`define VFDCR_ADDR_CONFIG 7'h04
`define VFDCR_ADDR_OUT_MAP 7'h06
`define VFDCR_ADDR_TEST 7'h07
`define VFDCR_ADDR_PUMP 7'h08
`define VFDCR_ADDR_FIL_A 7'h0A
`define VFDCR_ADDR_FIL_B 7'h0B
`define VFDCR_ADDR_AUX0 7'h0C
`define VFDCR_ADDR_AUX1 7'h0D
`define VFDCR_ADDR_SHIFT_LIM 7'h0E
`define VFDCR_ADDR_CELL_LO 7'h20
`define VFDCR_ADDR_ANN_LO 7'h50
`define VFDCR_ADDR_CELL_HI 7'h7F

// Frame layout
`define VFDCR_FRAME_W 16
`define VFDCR_FRAME_RD_BIT 15
`define VFDCR_CELLS 96
`define VFDCR_MAP_DEPTH 128

// Configuration register fields
`define VFDCR_CFG_S 0
`define VFDCR_CFG_L 1
`define VFDCR_CFG_B 2
`define VFDCR_CFG_T 4
`define VFDCR_CFG_R 5
`define VFDCR_CFG_M 6
`define VFDCR_CFG_P 7
`define VFDCR_CHAR_DP 7
`define VFDCR_MAP_PTR_SET 7

// Output pin function field (bits 7:6 of a pin config register)
`define VFDCR_FN_LEVEL 2'h0
`define VFDCR_FN_WAVE 2'h1
`define VFDCR_FN_DOUT 2'h2

// Reset values
`define VFDCR_RST_SHIFT_LIM 7'h01
`define VFDCR_RST_AUX1 8'h01
`define VFDCR_RST_MAP_PTR 7'h00

// Timing: one multiplex period is 100 us of a 4 MHz oscillator
`define VFDCR_MUX_PERIOD_US 100
`define VFDCR_OSC_MHZ 4
`define VFDCR_MUX_OSC_COUNT (`VFDCR_MUX_PERIOD_US * `VFDCR_OSC_MHZ)
// Blink half periods, counted in multiplex periods
`define VFDCR_BLINK_FAST 5'h0F
`define VFDCR_BLINK_SLOW 5'h1F

`endif

// *** logic/vfdcr_pkg.sv ***
package vfdcr_pkg;
  `include "vfdcr_params.svh"

  // Power sequencing of the multiplex engine
  typedef enum logic [1:0] {
    VFDCR_PW_RUN,
    VFDCR_PW_DRAIN,
    VFDCR_PW_OFF,
    VFDCR_PW_WAKE
  } vfdcr_pw_t;

  // Whole state of the register block
  typedef struct packed {
    logic sclk_p;
    logic cs_p;
    logic osc_p;
    logic [`VFDCR_FRAME_W-1:0] sh;
    logic [`VFDCR_CELLS-1:0][7:0] cells;
    logic [`VFDCR_MAP_DEPTH-1:0][7:0] omap;
    logic [6:0] map_ptr;
    logic cfg_s;
    logic cfg_l;
    logic cfg_b;
    logic cfg_m;
    logic mode_act;
    logic [5:0] grids;
    logic [6:0] shlim;
    logic blank_pol;
    logic test;
    logic [7:0] pump_cfg;
    logic [7:0] fa_cfg;
    logic [7:0] fb_cfg;
    logic [7:0] a0_cfg;
    logic [7:0] a1_cfg;
    logic [8:0] osc_cnt;
    logic [5:0] grid_idx;
    logic [4:0] blink_cnt;
    logic blink_ph;
    logic sq;
    vfdcr_pw_t pw;
    logic dout;
    logic blank_o;
    logic pump_o;
    logic fa_o;
    logic fb_o;
    logic a0_o;
    logic a1_o;
    logic dual_o;
  } vfdcr_state_t;

  // Synchroniser stages
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } vfdcr_sync_t;
endpackage : vfdcr_pkg

// *** logic/vfdcr_sync.sv ***
`timescale 1ns/1ns
// Two-stage synchroniser for the asynchronous pins
module vfdcr_sync
  import vfdcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [3:0] pins_i,
  output logic [3:0] sync_o
);
  vfdcr_sync_t st_q; // Both stages
  vfdcr_sync_t st_d; // Next value

  // Stage one is read only by stage two
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins_i;
    st_d.s2 = st_q.s1;
  end

  // Idle pins reset high: chip select and clock rest high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= '{s1: 4'hF, s2: 4'hF};
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule : vfdcr_sync

// *** sim/vfdcr_host.sv ***
`timescale 1ns/1ns
// Host controller model: drives frames on the serial pins, MSB first
module vfdcr_host (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  output logic done_o,
  output logic [15:0] rx_o
);
  logic idle_q; // High between frames
  // Select inactive and clock low from time zero
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    done_o = 1'b0;
    rx_o = 16'h0000;
    idle_q = 1'b1;
  end
  // Data is not held between frames, so no stale bit can look valid
  always @(posedge clk_i) begin
    if (idle_q) begin
      din_o <= ~din_o;
    end
  end
  // One frame; sel low keeps select high while the pins still toggle
  task automatic xfer(input logic [15:0] w, input logic sel);
    @(posedge clk_i);
    idle_q <= 1'b0;
    cs_n_o <= ~sel;
    repeat (4) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= 1'b0;
      din_o <= w[i];
      // Long low phase leaves room for the pin synchronisers
      repeat (5) @(posedge clk_i);
      sclk_o <= 1'b1;
      rx_o <= {rx_o[14:0], dout_i};
      repeat (3) @(posedge clk_i);
    end
    // Select rises while the clock is still high
    cs_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    sclk_o <= 1'b0;
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    idle_q <= 1'b1;
  endtask : xfer
endmodule : vfdcr_host

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  // Note per frame: compare read-back or not
  typedef struct packed {
    logic want;
    logic [14:0] exp;
    logic [14:0] mask;
  } vfdcr_exp_t;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic osc = 1'b0; // Multiplex oscillator, sped up to shorten periods
  logic sclk, cs_n, din, done;
  logic [15:0] rx;
  logic blank, pump, fa, fb, a0, a1, dual;
  wire logic [3:0] pv = {blank, pump, fa, fb};
  vfdcr_exp_t exp_q[$];
  vfdcr_exp_t e;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h8955;
  int cyc = 0;

  // System clock and unrelated oscillator
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    forever #30 osc = ~osc;
  end

  vfdcr_top vfdcr_top_i (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(1'b1),
    .sclk_i(sclk),
    .cs_n_i(cs_n),
    .din_i(din),
    .multiplex_osc_i(osc),
    .tube_blank_out_o(blank),
    .pump_out_o(pump),
    .filament_drive_a_o(fa),
    .filament_drive_b_o(fb),
    .aux_out_zero_o(a0),
    .aux_out_one_o(a1),
    .dual_row_o(dual)
  );

  // Serial out is routed to the first aux pin
  vfdcr_host vfdcr_host_i (
    .clk_i(clk_i),
    .dout_i(a0),
    .sclk_o(sclk),
    .cs_n_o(cs_n),
    .din_o(din),
    .done_o(done),
    .rx_o(rx)
  );

  // Verdict and end of run
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // Compare address and data shifted back out
  task automatic chk_rd(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd

  // Compare pin levels
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t pins=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    exp_q.push_back('0);
    vfdcr_host_i.xfer({1'b0, a, d}, 1'b1);
  endtask : wr

  // Read frame, then a no-op frame that carries the answer out
  task automatic rd(input logic [6:0] a, input logic [7:0] x,
                    input logic [7:0] m);
    exp_q.push_back('0);
    vfdcr_host_i.xfer({1'b1, a, 8'h00}, 1'b1);
    exp_q.push_back({1'b1, a, x & m, 7'h7F, m});
    vfdcr_host_i.xfer(16'h0000, 1'b1);
  endtask : rd

  // OR and AND of the pin vector over n cycles
  task automatic watch(input int n, output logic [3:0] o,
                       output logic [3:0] a);
    o = 4'h0;
    a = 4'hF;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      o = o | pv;
      a = a & pv;
    end
  endtask : watch

  // Bounded wait for a blanking level
  task automatic wait_blank(input logic v, input int n);
    int k;
    k = 0;
    // Look just after the edge, once the outputs have settled
    while (blank !== v && k < n) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk_pin({3'h0, blank}, {3'h0, v});
  endtask : wait_blank

  // Result watcher: oldest note taken at each finished frame
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      e = exp_q.pop_front();
      if (e.want) begin
        chk_rd(rx[14:0] & e.mask, e.exp);
      end
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      results();
    end
  end

  // Main sequence
  initial begin
    logic [3:0] o, a;
    logic [6:0] ad;
    logic [7:0] d, v20;
    logic [27:0] tb;
    tb = {7'h20, 7'h4F, 7'h50, 7'h7F};
    v20 = 8'h00;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    chk_pin(pv, 4'h8);
    chk_pin({1'b0, a0, a1, dual}, 4'h2);
    wr(7'h0C, 8'h80);
    rd(7'h04, 8'h00, 8'h7F);
    // Boundary cells first, then random ones, written in shutdown
    for (int k = 0; k < 8; k++) begin
      ad = (k < 4) ? tb[27-7*k -: 7] :
           7'h20 + 7'($unsigned($random(seed)) % 96);
      d = 8'($random(seed));
      if (ad == 7'h20) begin
        v20 = d;
      end
      wr(ad, d);
      rd(ad, d, 8'hFF);
    end
    // Waves configured but held low while shut down
    wr(7'h08, 8'h40);
    wr(7'h0A, 8'h40);
    wr(7'h0B, 8'h40);
    watch(3000, o, a);
    chk_pin({a[3], o[2:0]}, 4'h8);
    // Wake with fast blink and two-row mode
    wr(7'h04, 8'h45);
    rd(7'h04, 8'h45, 8'h7F);
    watch(1000, o, a);
    chk_pin({a[3], 3'h0}, 4'h8);
    wait_blank(1'b0, 8000);
    chk_pin({3'h0, dual}, 4'h1);
    watch(3000, o, a);
    chk_pin({1'b0, o[2:0]}, 4'h7);
    // Sync is one-shot and forces the blink phase
    wr(7'h04, 8'h55);
    rd(7'h04, 8'hC5, 8'hFF);
    // Lock: grids, shift limit and map data refuse writes
    wr(7'h03, 8'h05);
    wr(7'h06, 8'h82);
    wr(7'h06, 8'h33);
    wr(7'h04, 8'h47);
    wr(7'h03, 8'h0A);
    wr(7'h0E, 8'h7F);
    wr(7'h06, 8'h82);
    wr(7'h06, 8'h11);
    rd(7'h03, 8'h05, 8'h3F);
    rd(7'h0E, 8'h01, 8'h7F);
    wr(7'h06, 8'h82);
    rd(7'h06, 8'h33, 8'hFF);
    // A frame with select high must change nothing
    exp_q.push_back('0);
    vfdcr_host_i.xfer({1'b0, 7'h20, ~v20}, 1'b0);
    rd(7'h20, v20, 8'hFF);
    // Global clear, one-shot
    wr(7'h04, 8'h67);
    rd(7'h20, 8'h00, 8'hFF);
    rd(7'h50, 8'h00, 8'hFF);
    rd(7'h04, 8'h47, 8'h7F);
    // Back to shutdown: period drains, then blanked and waves low
    wr(7'h04, 8'h46);
    watch(4000, o, a);
    watch(2000, o, a);
    chk_pin({a[3], o[2:0]}, 4'h8);
    // Display test overrides shutdown
    wr(7'h07, 8'h01);
    wait_blank(1'b0, 20000);
    results();
  end
endmodule : testbench
